// ===== sctm_pkg.sv
// Package of the slow clock real-time timer: register map, field layout,
// reset values and timing counts.
// Assumes a 32-bit APB register bus with byte addresses.
package sctm_pkg;

    localparam int unsigned ADDR_WIDTH = 8;

    // Register byte offsets.
    localparam logic [7:0] OFFSET_MODE   = 8'h00;
    localparam logic [7:0] OFFSET_ALARM  = 8'h04;
    localparam logic [7:0] OFFSET_VALUE  = 8'h08;
    localparam logic [7:0] OFFSET_STATUS = 8'h0c;

    // Field positions in the mode register.
    localparam int unsigned MODE_PRESCALE_LSB    = 0;
    localparam int unsigned MODE_ALARM_IEN_BIT   = 16;
    localparam int unsigned MODE_INCR_IEN_BIT    = 17;
    localparam int unsigned MODE_RESTART_BIT     = 18;
    localparam int unsigned MODE_DISABLE_BIT     = 20;
    localparam int unsigned MODE_SECOND_TICK_BIT = 24;

    // Field positions in the status register.
    localparam int unsigned STATUS_ALARM_BIT = 0;
    localparam int unsigned STATUS_INCR_BIT  = 1;

    // Reset values.
    localparam logic [15:0] PRESCALE_RESET = 16'h8000;
    localparam logic [31:0] ALARM_RESET    = 32'hffff_ffff;
    localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;

    // Slow clock edges between a status read and a new interrupt.
    localparam logic [1:0] IRQ_READ_DELAY = 2'h2;

    typedef struct packed {
        logic        second_tick_select;
        logic        timer_disable;
        logic        increment_irq_enable;
        logic        alarm_irq_enable;
        logic [15:0] prescale_value;
    } sctm_mode_type;

    typedef struct packed {
        logic increment_flag;
        logic alarm_flag;
    } sctm_status_type;

endpackage : sctm_pkg

// ===== sctm_prescaler.sv
// Programmable 16-bit divider of the slow clock edge stream.
// Assumes slow_edge is a one-cycle pulse already in the pclk domain.
`timescale 1ns/10ps
module sctm_prescaler
    import sctm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow_edge,
    input  wire logic        enable,
    input  wire logic        restart,
    input  wire logic [15:0] prescale_value,
    output logic             roll_over
);

    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_roll_over;

    // A value of zero divides by 65536, the full 16-bit span.
    always_comb begin
        next_count     = count;
        next_roll_over = 1'b0;
        if (restart) begin
            next_count = prescale_value;
        end else if (enable && slow_edge) begin
            if (count == 16'h0001) begin
                next_count     = prescale_value;
                next_roll_over = 1'b1;
            end else begin
                next_count = count - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count     <= PRESCALE_RESET;
            roll_over <= 1'b0;
        end else begin
            count     <= next_count;
            roll_over <= next_roll_over;
        end
    end

endmodule : sctm_prescaler

// ===== sctm_timer.sv
// Slow clock real-time timer with an APB register slave.
// Assumes slow_clock and second_tick come from other clock domains and are
// much slower than pclk; both are resynchronised here.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Operation
// - Sixteen-bit prescaler divides the slow clock
// - Prescale value resets to 0x8000
// - Thirty-two-bit up counter wraps to zero
// - Every prescaler roll-over sets increment flag
// - Second tick select counts calendar ticks
// - Otherwise roll-over increments the counter
// - Interrupt returns two slow cycles after read
// - Count matching alarm sets alarm flag
// - Alarm register resets to all ones
// - Alarm flag always drives alarm output
// - Status read clears both flags
// - Restart reloads divider and clears counter
// - Disable bit stops divider, counter and alarm match
module sctm_timer
    import sctm_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  slow_clock,
    input  wire logic                  second_tick,
    output logic                       timer_irq,
    output logic                       timer_alarm
);

    sctm_mode_type   mode;
    sctm_mode_type   next_mode;
    sctm_status_type status;
    sctm_status_type next_status;
    logic [31:0]     alarm_value;
    logic [31:0]     next_alarm_value;
    logic [31:0]     current_count;
    logic [31:0]     next_current_count;
    logic            restart;
    logic            next_restart;
    logic            match_prev;
    logic            next_match_prev;
    logic [1:0]      irq_hold;
    logic [1:0]      next_irq_hold;
    logic            next_timer_irq;
    logic            next_timer_alarm;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;

    // Synchronisers and edge detectors for the two outside clocks.
    logic [2:0] slow_sync;
    logic [2:0] tick_sync;
    logic       slow_edge;
    logic       tick_edge;
    logic       roll_over;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_sync <= 3'h0;
            tick_sync <= 3'h0;
        end else begin
            slow_sync <= {slow_sync[1:0], slow_clock};
            tick_sync <= {tick_sync[1:0], second_tick};
        end
    end

    // Only the second and third stages feed the edge detectors, so a
    // first stage that goes metastable never reaches the counters.
    assign slow_edge = slow_sync[1] & ~slow_sync[2];
    assign tick_edge = tick_sync[1] & ~tick_sync[2];

    // Holding the divider while disabled stops its count and roll-overs;
    // the synchronisers and the interrupt hold-off keep running.
    sctm_prescaler u_prescaler (
        .pclk           (pclk),
        .presetn        (presetn),
        .slow_edge      (slow_edge),
        .enable         (!mode.timer_disable),
        .restart        (restart),
        .prescale_value (mode.prescale_value),
        .roll_over      (roll_over)
    );

    // Bus decode.
    logic access;
    logic wr_access;
    logic rd_access;
    logic addr_valid;
    logic status_read;

    assign access      = psel && penable && pready;
    assign wr_access   = access && pwrite;
    assign rd_access   = access && !pwrite;
    assign addr_valid  = (paddr == OFFSET_MODE) || (paddr == OFFSET_ALARM) ||
                         (paddr == OFFSET_VALUE) ||
                         (paddr == OFFSET_STATUS);
    assign status_read = rd_access && (paddr == OFFSET_STATUS);

    // Writes to the mode and alarm registers, with byte strobes.
    // The mode word is rebuilt from its fields, so the restart bit,
    // which is never stored, always reads back as zero.
    logic [31:0] mode_word;
    logic [31:0] mode_written;
    logic [31:0] alarm_written;

    always_comb begin
        mode_word = 32'h0;
        mode_word[MODE_PRESCALE_LSB +: 16]  = mode.prescale_value;
        mode_word[MODE_ALARM_IEN_BIT]       = mode.alarm_irq_enable;
        mode_word[MODE_INCR_IEN_BIT]        = mode.increment_irq_enable;
        mode_word[MODE_DISABLE_BIT]         = mode.timer_disable;
        mode_word[MODE_SECOND_TICK_BIT]     = mode.second_tick_select;
        for (int i = 0; i < 4; i++) begin
            mode_written[8*i +: 8]  = pstrb[i] ? pwdata[8*i +: 8]
                                               : mode_word[8*i +: 8];
            alarm_written[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8]
                                               : alarm_value[8*i +: 8];
        end
    end

    // Register file next values.
    always_comb begin
        next_mode        = mode;
        next_alarm_value = alarm_value;
        next_restart     = 1'b0;
        if (wr_access && (paddr == OFFSET_MODE)) begin
            next_mode.prescale_value =
                mode_written[MODE_PRESCALE_LSB +: 16];
            next_mode.alarm_irq_enable     = mode_written[MODE_ALARM_IEN_BIT];
            next_mode.increment_irq_enable = mode_written[MODE_INCR_IEN_BIT];
            next_mode.timer_disable        = mode_written[MODE_DISABLE_BIT];
            next_mode.second_tick_select   =
                mode_written[MODE_SECOND_TICK_BIT];
            // Restart lives for one cycle only, as a pulse to the divider
            // and the counter.
            next_restart = pstrb[MODE_RESTART_BIT / 8] &&
                           pwdata[MODE_RESTART_BIT];
        end
        // The count register is read-only; writes to it are dropped.
        if (wr_access && (paddr == OFFSET_ALARM)) begin
            next_alarm_value = alarm_written;
        end
    end

    // Counter and alarm compare. Only the first cycle of equality counts
    // as a match, so a flag cleared while the count still equals the
    // alarm value stays clear.
    logic count_step;
    logic match_now;

    always_comb begin
        if (mode.second_tick_select) begin
            count_step = tick_edge;
        end else begin
            count_step = roll_over;
        end
        next_current_count = current_count;
        if (restart) begin
            next_current_count = COUNT_RESET;
        end else if (!mode.timer_disable && count_step) begin
            next_current_count = current_count + 32'h1;
        end

        match_now       = (current_count == alarm_value);
        next_match_prev = match_now;
    end

    // Sticky flags: a read or a written one clears them, an event sets
    // them, and the event wins when both fall in one cycle.
    always_comb begin
        next_status = status;
        if (status_read) begin
            next_status = '0;
        end else if (wr_access && (paddr == OFFSET_STATUS)) begin
            if (pstrb[0] && pwdata[STATUS_ALARM_BIT]) begin
                next_status.alarm_flag = 1'b0;
            end
            if (pstrb[0] && pwdata[STATUS_INCR_BIT]) begin
                next_status.increment_flag = 1'b0;
            end
        end
        // Events win over a clear in the same cycle.
        if (roll_over) begin
            next_status.increment_flag = 1'b1;
        end
        // A disabled timer raises no alarm even if the frozen count
        // equals a newly written alarm value.
        if (match_now && !match_prev && !mode.timer_disable) begin
            next_status.alarm_flag = 1'b1;
        end
    end

    // Interrupt hold-off: after a status read the interrupt stays low
    // until two slow clock edges have passed, which gives a handler time
    // to return before a pending event re-enters it.
    always_comb begin
        next_irq_hold = irq_hold;
        if (status_read) begin
            next_irq_hold = IRQ_READ_DELAY;
        end else if (slow_edge && (irq_hold != 2'h0)) begin
            next_irq_hold = irq_hold - 2'h1;
        end

        next_timer_irq = (next_irq_hold == 2'h0) &&
            ((next_status.alarm_flag && mode.alarm_irq_enable) ||
             (next_status.increment_flag &&
              mode.increment_irq_enable));
        next_timer_alarm = next_status.alarm_flag;
    end

    // APB answer: one wait-free access phase, data registered. An
    // unmapped address answers with an error and changes nothing.
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !addr_valid;
        next_prdata  = 32'h0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFFSET_MODE:   next_prdata = mode_word;
                OFFSET_ALARM:  next_prdata = alarm_value;
                OFFSET_VALUE:  next_prdata = current_count;
                OFFSET_STATUS: begin
                    next_prdata[STATUS_ALARM_BIT] = status.alarm_flag;
                    next_prdata[STATUS_INCR_BIT]  = status.increment_flag;
                end
                default:       next_prdata = 32'h0;
            endcase
        end
    end

    // Register file.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.prescale_value       <= PRESCALE_RESET;
            mode.alarm_irq_enable     <= 1'b0;
            mode.increment_irq_enable <= 1'b0;
            mode.timer_disable        <= 1'b0;
            mode.second_tick_select   <= 1'b0;
            alarm_value               <= ALARM_RESET;
            restart                   <= 1'b0;
        end else begin
            mode        <= next_mode;
            alarm_value <= next_alarm_value;
            restart     <= next_restart;
        end
    end

    // Counter and its alarm compare history.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_count <= COUNT_RESET;
            match_prev    <= 1'b0;
        end else begin
            current_count <= next_current_count;
            match_prev    <= next_match_prev;
        end
    end

    // Sticky status flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // Interrupt hold-off and the two event outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_hold    <= 2'h0;
            timer_irq   <= 1'b0;
            timer_alarm <= 1'b0;
        end else begin
            irq_hold    <= next_irq_hold;
            timer_irq   <= next_timer_irq;
            timer_alarm <= next_timer_alarm;
        end
    end

    // Bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : sctm_timer

// ===== sctm_timer_monitor.sv
// Checker of the slow clock real-time timer, watching top-level ports.
// Assumes slow_clock is much slower than pclk.
`timescale 1ns/10ps
module sctm_timer_monitor
    import sctm_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  slow_clock,
    input wire logic                  second_tick,
    input wire logic                  timer_irq,
    input wire logic                  timer_alarm
);
    logic       acc;
    logic       clr_any;
    logic       stat_rd;
    logic [1:0] ien;
    logic [1:0] next_ien;
    assign acc = psel && penable && pready;
    assign clr_any = acc && (paddr == OFFSET_STATUS);
    assign stat_rd = clr_any && !pwrite;
    // Shadow of the two interrupt enables in the mode register.
    always_comb begin
        next_ien = ien;
        if (acc && pwrite && paddr == OFFSET_MODE && pstrb[2]) begin
            next_ien = pwdata[17:16];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ien <= 2'h0;
        else ien <= next_ien;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_MAP: assert property (pready && paddr[1:0] == 2'h0
        && paddr <= OFFSET_STATUS |-> !pslverr)
        else $error("error on mapped register");
    AST_WRITE_DATA: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data driven on write");
    AST_IRQ_HOLD: assert property (stat_rd |=> !timer_irq [*3])
        else $error("interrupt too soon after status read");
    AST_ALARM_CLEAR: assert property (stat_rd |=> !timer_alarm)
        else $error("alarm output not cleared by read");
    AST_ALARM_FALL: assert property ($fell(timer_alarm)
        |-> $past(clr_any))
        else $error("alarm output fell without clear");
    AST_IRQ_GATE: assert property (timer_irq
        |-> ien != 0 || $past(ien) != 0)
        else $error("interrupt with both enables off");
    cover property (stat_rd && timer_alarm);
    cover property ($rose(timer_irq));
    cover property (pready && pslverr);
endmodule : sctm_timer_monitor

bind sctm_timer sctm_timer_monitor i_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clock(slow_clock), .second_tick(second_tick),
    .timer_irq(timer_irq), .timer_alarm(timer_alarm));

// ===== slow_clock_real_time_timer_tb.sv
// Self-checking bench of the slow clock real-time timer.
// Assumes the bench drives APB and both slow inputs itself.
`timescale 1ns/10ps
module slow_clock_real_time_timer_tb;
    import sctm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, slow_clock, second_tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic        pready, pslverr, timer_irq, timer_alarm, e;
    int          errors, tests_run;
    sctm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_clock(slow_clock), .second_tick(second_tick),
        .timer_irq(timer_irq), .timer_alarm(timer_alarm));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    task automatic tally_and_finish;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 0;
        penable <= 0;
        // One idle cycle, so the next call never drives psel in this step.
        @(posedge pclk);
        if (n >= 20) begin
            errors++;
            tally_and_finish();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input string nm);
        apb(0, a, 32'h0);
        chk(nm, r, x);
    endtask : rdc
    // Slow clock stands still between bursts; period is 8 pclk.
    task automatic pulses(input logic t, input int n);
        repeat (n) begin
            if (t) second_tick <= 1; else slow_clock <= 1;
            repeat (4) @(posedge pclk);
            second_tick <= 0;
            slow_clock <= 0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask : pulses
    task automatic t_reset;
        rdc(OFFSET_MODE, 32'h0000_8000, "mode");
        rdc(OFFSET_ALARM, 32'hffff_ffff, "alarm");
        rdc(OFFSET_VALUE, 32'h0, "value");
        rdc(OFFSET_STATUS, 32'h0, "status");
        apb(0, 8'h10, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
    endtask : t_reset
    task automatic t_count;
        apb(1, OFFSET_MODE, 32'h0004_0003);
        pulses(0, 6);
        rdc(OFFSET_MODE, 32'h3, "mode prescale");
        rdc(OFFSET_VALUE, 32'h2, "count");
        rdc(OFFSET_VALUE, 32'h2, "count again");
        rdc(OFFSET_STATUS, 32'h2, "incr flag");
        rdc(OFFSET_STATUS, 32'h0, "flags cleared");
    endtask : t_count
    task automatic t_alarm;
        apb(1, OFFSET_MODE, 32'h0004_0003);
        apb(1, OFFSET_ALARM, 32'h2);
        apb(1, OFFSET_MODE, 32'h0001_0003);
        pulses(0, 5);
        chk("alarm early", {31'h0, timer_alarm}, 32'h0);
        pulses(0, 1);
        chk("alarm out", {31'h0, timer_alarm}, 32'h1);
        chk("alarm irq", {31'h0, timer_irq}, 32'h1);
        rdc(OFFSET_STATUS, 32'h3, "both flags");
        @(negedge pclk);
        chk("alarm cleared", {31'h0, timer_alarm}, 32'h0);
        chk("irq cleared", {31'h0, timer_irq}, 32'h0);
        @(posedge pclk);
        apb(1, OFFSET_MODE, 32'h0002_0003);
        pulses(0, 3);
        chk("incr irq", {31'h0, timer_irq}, 32'h1);
        rdc(OFFSET_STATUS, 32'h2, "incr only");
        pulses(0, 2);
        rdc(OFFSET_STATUS, 32'h0, "no event");
        pulses(0, 1);
        chk("irq held", {31'h0, timer_irq}, 32'h0);
        pulses(0, 1);
        chk("irq after hold", {31'h0, timer_irq}, 32'h1);
        rdc(OFFSET_STATUS, 32'h2, "incr held");
    endtask : t_alarm
    task automatic t_second;
        apb(1, OFFSET_MODE, 32'h0104_0003);
        apb(1, OFFSET_ALARM, 32'hffff_ffff);
        pulses(1, 2);
        pulses(0, 3);
        rdc(OFFSET_VALUE, 32'h2, "tick count");
        rdc(OFFSET_STATUS, 32'h2, "incr on tick");
    endtask : t_second
    task automatic t_disable;
        apb(1, OFFSET_MODE, 32'h0004_0003);
        rdc(OFFSET_VALUE, 32'h0, "restart");
        apb(1, OFFSET_MODE, 32'h0010_0003);
        pulses(0, 6);
        rdc(OFFSET_VALUE, 32'h0, "frozen");
        rdc(OFFSET_STATUS, 32'h0, "no events");
    endtask : t_disable
    initial begin
        errors = 0;
        tests_run = 0;
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; pstrb = 4'hf; slow_clock = 0; second_tick = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_count();
        t_alarm();
        t_second();
        t_disable();
        tally_and_finish();
    end
endmodule : slow_clock_real_time_timer_tb
